//--- segment_lcd_scanner.sv
// Segment LCD scanner: control register, display RAM window and segment/common scan.
// Assumes a page-0 register port from the processor and a watch clock pulse from
// the watch timer; analog bias levels are built outside from the digital outputs.
`timescale 1ns/10ps
`include "segment_lcd_consts.svh"

module segment_lcd_scanner (
  input  wire logic        clock_in,         // System clock; watch clock pulses arrive as enables on it
  input  wire logic        rst_in,           // Sync reset, high
  input  wire logic [7:0]  reg_addr_in,      // Page-0 register address
  input  wire logic        reg_wr_in,        // Write strobe
  input  wire logic        reg_rd_in,        // Read strobe
  input  wire logic [7:0]  reg_wdata_in,     // Write data
  output logic      [7:0]  reg_rdata_out,    // Read data, next cycle
  output logic             reg_hit_out,      // Address decoded here
  input  wire logic        watch_tick_in,    // Watch clock pulse
  output logic      [31:0] segment_outputs,  // Segment select levels
  output logic      [3:0]  common_outputs,   // Active common, one-hot
  output logic             frame_start_out,  // Pulse at phase 0
  output logic             lcd_on_out,       // Display enabled
  output logic             bias_half_out,    // 1 = 1/2 bias, 0 = 1/3 bias
  output logic      [1:0]  duty_out,         // Duty field
  output logic             bias_res_off_out  // Internal bias resistors off
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] commons_of(input segment_lcd_pkg::duty_t d);
    case (d)
      segment_lcd_pkg::DUTY_QUARTER: commons_of = 3'h4;
      segment_lcd_pkg::DUTY_THIRD:   commons_of = 3'h3;
      segment_lcd_pkg::DUTY_HALF:    commons_of = 3'h2;
      segment_lcd_pkg::DUTY_STATIC:  commons_of = 3'h1;
      default:                       commons_of = 3'h4;
    endcase
  endfunction

  function automatic logic [1:0] phase_index(input segment_lcd_pkg::phase_t p);
    case (p)
      segment_lcd_pkg::PHASE_COM0: phase_index = 2'h0;
      segment_lcd_pkg::PHASE_COM1: phase_index = 2'h1;
      segment_lcd_pkg::PHASE_COM2: phase_index = 2'h2;
      segment_lcd_pkg::PHASE_COM3: phase_index = 2'h3;
      default:                     phase_index = 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]                  ctrl_r;
  logic [7:0]                  ram_r [`DISP_RAM_BYTES];
  segment_lcd_pkg::phase_t     phase_r;
  segment_lcd_pkg::phase_t     phase_nxt;
  segment_lcd_pkg::duty_t      duty;
  logic                        scan_tick;
  logic                        ctrl_hit;
  logic                        ram_hit;
  logic [2:0]                  ncom;
  logic [1:0]                  pidx;

  assign ctrl_hit = (reg_addr_in == `LCD_CONTROL_ADDR);
  assign ram_hit  = (reg_addr_in[7:4] == `DISP_RAM_PAGE);
  assign reg_hit_out = ctrl_hit || ram_hit;
  assign duty = segment_lcd_pkg::duty_t'(ctrl_r[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB]);
  assign ncom = commons_of(duty);
  assign pidx = phase_index(phase_r);

  // Field layout chosen here except the fixed resistor bit
  assign lcd_on_out       = ctrl_r[`CTRL_ON_BIT];
  assign bias_half_out    = ctrl_r[`CTRL_BIAS_BIT];
  assign duty_out         = ctrl_r[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB];
  assign bias_res_off_out = ctrl_r[`CTRL_RES_OFF_BIT];

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl_r <= `LCD_CONTROL_RESET;
    end else if (reg_wr_in && ctrl_hit) begin
      ctrl_r <= reg_wdata_in;
    end
  end

  // RAM is plain storage; bits for commons unused at the selected duty keep whatever software wrote
  always_ff @(posedge clock_in) begin
    if (reg_wr_in && ram_hit) begin
      ram_r[reg_addr_in[3:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (ctrl_hit) begin
        reg_rdata_out <= ctrl_r;
      end else if (ram_hit) begin
        reg_rdata_out <= ram_r[reg_addr_in[3:0]];
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer

  // Scan clock needs the watch timer running; no watch ticks, no scan
  scan_divider u_div (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .run_in        (lcd_on_out),
    .watch_tick_in (watch_tick_in),
    .scan_sel_in   (segment_lcd_pkg::scan_clock_select_t'(ctrl_r[`CTRL_CLK_MSB:`CTRL_CLK_LSB])),
    .scan_tick_out (scan_tick)
  );

  always_comb begin
    case (phase_r)
      segment_lcd_pkg::PHASE_COM0: phase_nxt = segment_lcd_pkg::PHASE_COM1;
      segment_lcd_pkg::PHASE_COM1: phase_nxt = segment_lcd_pkg::PHASE_COM2;
      segment_lcd_pkg::PHASE_COM2: phase_nxt = segment_lcd_pkg::PHASE_COM3;
      segment_lcd_pkg::PHASE_COM3: phase_nxt = segment_lcd_pkg::PHASE_COM0;
      default:                     phase_nxt = segment_lcd_pkg::PHASE_COM0;
    endcase
    // Wrap after the last common in use, also after a duty change mid-frame
    if ({1'b0, pidx} + 3'h1 >= ncom) begin
      phase_nxt = segment_lcd_pkg::PHASE_COM0;
    end
  end

  // Runs on whatever clock feeds clock_in, so sub-clock operation survives idle
  always_ff @(posedge clock_in) begin
    if (rst_in || !lcd_on_out) begin
      phase_r <= segment_lcd_pkg::PHASE_COM0;
    end else if (scan_tick) begin
      phase_r <= phase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  // Byte k: low nibble segment 2k, high nibble segment 2k+1, bit n = common n
  always_ff @(posedge clock_in) begin
    if (rst_in || !lcd_on_out) begin
      segment_outputs <= 32'h0000_0000;
      common_outputs  <= 4'h0;
      frame_start_out <= 1'b0;
    end else begin
      for (int s = 0; s < `NUM_SEGMENTS; s++) begin
        segment_outputs[s] <= ram_r[s / 2][(s % 2) * 4 + pidx];
      end
      common_outputs  <= ({1'b0, pidx} < ncom) ? 4'h1 << pidx : 4'h0;
      frame_start_out <= scan_tick && (phase_nxt == segment_lcd_pkg::PHASE_COM0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic seg0_bit;
  assign seg0_bit = ram_r[0][pidx];

  a_ctrl_reset: assert property (@(posedge clock_in)
    rst_in |=> ctrl_r == 8'h00 && !lcd_on_out)
    else $error("control not cleared by reset");

  a_off_dark: assert property (@(posedge clock_in) disable iff (rst_in)
    !lcd_on_out |=> segment_outputs == 32'h0000_0000 && common_outputs == 4'h0)
    else $error("outputs active while display off");

  a_off_phase: assert property (@(posedge clock_in) disable iff (rst_in)
    !lcd_on_out |=> phase_r == segment_lcd_pkg::PHASE_COM0)
    else $error("sequencer not held while off");

  a_commons_duty: assert property (@(posedge clock_in) disable iff (rst_in)
    (common_outputs >> $past(ncom)) == 4'h0)
    else $error("common beyond duty active");

  a_seg_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    lcd_on_out ##1 lcd_on_out |-> segment_outputs[0] == $past(seg0_bit))
    else $error("segment 0 not following RAM bit");

  a_phase_step: assert property (@(posedge clock_in) disable iff (rst_in)
    (lcd_on_out && scan_tick && pidx == 2'h0 && ncom > 3'h1)
      |=> phase_r == segment_lcd_pkg::PHASE_COM1)
    else $error("phase did not advance on scan tick");

  a_phase_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    (lcd_on_out && !scan_tick) |=> $stable(phase_r))
    else $error("phase moved without scan tick");

  a_ram_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == `DISP_RAM_FIRST) |=> ram_r[0] == $past(reg_wdata_in))
    else $error("display RAM write lost");

  a_res_bit: assert property (@(posedge clock_in) disable iff (rst_in)
    (reg_wr_in && ctrl_hit) |=> bias_res_off_out == $past(reg_wdata_in[7]))
    else $error("resistor disconnect not written");

  a_static_com: assert property (@(posedge clock_in) disable iff (rst_in)
    (lcd_on_out && duty == segment_lcd_pkg::DUTY_STATIC) [*2] |-> common_outputs == 4'h1)
    else $error("static mode not on common 0");

  c_static_on: cover property (@(posedge clock_in) disable iff (rst_in)
    lcd_on_out && duty == segment_lcd_pkg::DUTY_STATIC && scan_tick);
  c_quarter_wrap: cover property (@(posedge clock_in) disable iff (rst_in)
    phase_r == segment_lcd_pkg::PHASE_COM3 ##1 phase_r == segment_lcd_pkg::PHASE_COM0);
  c_third_frame: cover property (@(posedge clock_in) disable iff (rst_in)
    duty == segment_lcd_pkg::DUTY_THIRD && frame_start_out);
  c_ram_read: cover property (@(posedge clock_in) disable iff (rst_in)
    reg_rd_in && ram_hit);

endmodule

//--- segment_lcd_consts.svh
// Offsets, field positions, reset values and divider counts of the segment LCD scanner.
// Assumes the including file needs plain `define constants only.
`ifndef SEGMENT_LCD_CONSTS_SVH
`define SEGMENT_LCD_CONSTS_SVH

`define LCD_CONTROL_ADDR   8'hd7
`define LCD_CONTROL_RESET  8'h00
`define DISP_RAM_PAGE      4'hb
`define DISP_RAM_FIRST     8'hb0
`define DISP_RAM_LAST      8'hbf
`define DISP_RAM_BYTES     16
`define NUM_SEGMENTS       32
`define NUM_COMMONS        4

`define CTRL_ON_BIT        0
`define CTRL_DUTY_LSB      1
`define CTRL_DUTY_MSB      2
`define CTRL_BIAS_BIT      3
`define CTRL_CLK_LSB       4
`define CTRL_CLK_MSB       5
`define CTRL_RES_OFF_BIT   7

`define DIV_64HZ           10'h200
`define DIV_128HZ          10'h100
`define DIV_256HZ          10'h080
`define DIV_512HZ          10'h040

`endif

//--- segment_lcd_pkg.sv
// Types shared by the segment LCD scanner and its scan divider.
// Assumes nothing beyond a SystemVerilog compiler.
package segment_lcd_pkg;

  typedef enum logic [1:0] {
    DUTY_QUARTER = 2'h0,
    DUTY_THIRD   = 2'h1,
    DUTY_HALF    = 2'h2,
    DUTY_STATIC  = 2'h3
  } duty_t;

  typedef enum logic [1:0] {
    SCAN_64HZ  = 2'h0,
    SCAN_128HZ = 2'h1,
    SCAN_256HZ = 2'h2,
    SCAN_512HZ = 2'h3
  } scan_clock_select_t;

  // Scan position; Gray-coded along the normal 0-1-2-3 walk
  typedef enum logic [1:0] {
    PHASE_COM0 = 2'h0,
    PHASE_COM1 = 2'h1,
    PHASE_COM2 = 2'h3,
    PHASE_COM3 = 2'h2
  } phase_t;

endpackage

//--- scan_divider.sv
// Scan clock divider: turns watch clock enable pulses into scan clock pulses.
// Assumes watch_tick_in is a one-cycle pulse at the 32.768 kHz watch clock rate.
`timescale 1ns/10ps
`include "segment_lcd_consts.svh"

module scan_divider (
  input  wire logic                                clock_in,      // System clock
  input  wire logic                                rst_in,        // Sync reset, high
  input  wire logic                                run_in,        // Display on
  input  wire logic                                watch_tick_in, // Watch clock pulse
  input  wire segment_lcd_pkg::scan_clock_select_t scan_sel_in,   // Scan rate
  output logic                                     scan_tick_out  // Scan clock pulse
);

  logic [9:0] count_r;
  logic [9:0] limit;

  always_comb begin
    case (scan_sel_in)
      segment_lcd_pkg::SCAN_64HZ:  limit = `DIV_64HZ;
      segment_lcd_pkg::SCAN_128HZ: limit = `DIV_128HZ;
      segment_lcd_pkg::SCAN_256HZ: limit = `DIV_256HZ;
      segment_lcd_pkg::SCAN_512HZ: limit = `DIV_512HZ;
      default:                     limit = `DIV_64HZ;
    endcase
  end

  // Held clear while off so the first phase after turn-on is full length
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_in) begin
      count_r       <= 10'h000;
      scan_tick_out <= 1'b0;
    end else if (watch_tick_in) begin
      if (count_r >= limit - 10'h001) begin
        count_r       <= 10'h000;
        scan_tick_out <= 1'b1;
      end else begin
        count_r       <= count_r + 10'h001;
        scan_tick_out <= 1'b0;
      end
    end else begin
      scan_tick_out <= 1'b0;
    end
  end

  a_tick_single: assert property (@(posedge clock_in) disable iff (rst_in)
    scan_tick_out |=> !scan_tick_out)
    else $error("scan tick longer than one cycle");

  a_tick_cause: assert property (@(posedge clock_in) disable iff (rst_in)
    scan_tick_out |-> $past(watch_tick_in) && $past(run_in))
    else $error("scan tick without watch tick");

endmodule

//--- lcd_glass.sv
// Passive four-common LCD glass: latches the dot state seen in each common phase.
// Assumes one-hot common levels and digital segment select levels from the scanner.
`timescale 1ns/10ps

module lcd_glass (
  input  wire logic         clock_in, // System clock
  input  wire logic [31:0]  seg_in,   // Segment select levels
  input  wire logic [3:0]   com_in,   // Active common, one-hot
  output logic      [127:0] dots_out  // Dot c*32+s lit
);
  // Glass only reacts while its common is driven; idle commons keep the old image
  always_ff @(posedge clock_in) begin
    for (int c = 0; c < 4; c++) begin
      if (com_in[c]) begin
        dots_out[c*32 +: 32] <= seg_in;
      end
    end
  end
endmodule

//--- test_segment_lcd_scanner.sv
// Self-checking bench for the segment LCD scanner with a passive glass model.
// Assumes watch ticks every second clock, so one scan phase is 2*N clocks.
`timescale 1ns/10ps

module test_segment_lcd_scanner;
  logic         clock_in;
  logic         rst_in;
  logic [7:0]   reg_addr_in;
  logic         reg_wr_in;
  logic         reg_rd_in;
  logic [7:0]   reg_wdata_in;
  logic         watch_tick_in;
  logic         tick_en;
  logic [7:0]   reg_rdata_out;
  logic         reg_hit_out;
  logic [31:0]  segment_outputs;
  logic [3:0]   common_outputs;
  logic         frame_start_out;
  logic         lcd_on_out;
  logic         bias_half_out;
  logic [1:0]   duty_out;
  logic         bias_res_off_out;
  logic [127:0] dots;
  logic [7:0]   ram_img [16];
  int           err_count;
  int           checked;

  segment_lcd_scanner DUT (
    .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out),
    .watch_tick_in(watch_tick_in), .segment_outputs(segment_outputs),
    .common_outputs(common_outputs), .frame_start_out(frame_start_out),
    .lcd_on_out(lcd_on_out), .bias_half_out(bias_half_out), .duty_out(duty_out),
    .bias_res_off_out(bias_res_off_out)
  );

  lcd_glass glass (.clock_in(clock_in), .seg_in(segment_outputs),
    .com_in(common_outputs), .dots_out(dots));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // Watch tick on every other clock while enabled
  always @(posedge clock_in) watch_tick_in <= #1 tick_en & ~watch_tick_in;

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in) #1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge clock_in) #1;
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in) #1;
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    // Let the combinational decode follow the new address before looking
    #1;
    chk(reg_hit_out, (a == 8'hd7) || (a[7:4] == 4'hb), "hit");
    @(posedge clock_in) #1;
    reg_rd_in = 1'b0;
    chk(reg_rdata_out, exp, "read data");
  endtask

  task automatic timeout(input string what);
    err_count++;
    $display("FAIL %0t: timeout on %s", $time, what);
    report_and_stop();
  endtask

  task automatic wait_com(input logic [3:0] c, input int bound);
    int n;
    n = 0;
    while (common_outputs !== c && n < bound) begin
      @(posedge clock_in) #1;
      n++;
    end
    if (common_outputs !== c) timeout("common walk");
  endtask

  task automatic wait_frame(input int bound, output int n);
    n = 0;
    do begin
      @(posedge clock_in) #1;
      n++;
    end while (frame_start_out !== 1'b1 && n < bound);
    if (frame_start_out !== 1'b1) timeout("frame start");
  endtask

  function automatic logic [31:0] exp_seg(input int c);
    logic [31:0] s;
    for (int k = 0; k < 32; k++) s[k] = ram_img[k/2][(k%2)*4 + c];
    return s;
  endfunction

  // One full scan check for a duty and scan clock select, then display off
  task automatic scan(input logic [1:0] duty, input logic [1:0] sel);
    int ncom;
    int per;
    int n;
    ncom = 4 - int'(duty);
    per = 2 * (64 << (3 - int'(sel)));
    wr(8'hd7, {2'b00, sel, duty == 2'h2, duty, 1'b1});
    chk(duty_out, duty, "duty");
    chk(lcd_on_out, 1'b1, "display on");
    chk(bias_half_out, duty == 2'h2, "bias");
    wait_frame(ncom * per + 20, n);
    for (int c = 0; c < ncom; c++) wait_com(4'h1 << c, per + 8);
    wait_com(4'h1, per + 8);
    for (int c = 0; c < ncom; c++) chk(dots[c*32 +: 32], exp_seg(c), "dots");
    wait_frame(ncom * per + 20, n);
    wait_frame(ncom * per + 20, n);
    chk(n, ncom * per, "frame period");
    wr(8'hd7, 8'h00);
    @(posedge clock_in) #1;
    chk(common_outputs, 4'h0, "commons off");
    chk(segment_outputs, 32'h0, "segments off");
    $display("test scan duty %0d select %0d done", duty, sel);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    checked = 0;
    rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_wdata_in = 8'h00;
    tick_en = 1'b0;
    repeat (16) @(posedge clock_in);
    #1 rst_in = 1'b0;
    chk(common_outputs, 4'h0, "reset commons");
    chk({lcd_on_out, bias_res_off_out, bias_half_out, duty_out}, 32'h0, "reset fields");
    rd(8'hd7, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      ram_img[k] = 8'(8'h5a ^ (8'h13 * k));
      wr(8'(8'hb0 + k), ram_img[k]);
    end
    for (int k = 0; k < 16; k++) rd(8'(8'hb0 + k), ram_img[k]);
    rd(8'haf, 8'h00);
    rd(8'hc0, 8'h00);
    wr(8'hd7, 8'hc0);
    wr(8'hd6, 8'hff);
    chk(bias_res_off_out, 1'b1, "resistors off");
    chk(lcd_on_out, 1'b0, "still off");
    rd(8'hd7, 8'hc0);
    // Second reset from a non-zero control value; display RAM must survive it
    @(posedge clock_in) #1;
    rst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1 rst_in = 1'b0;
    chk(bias_res_off_out, 1'b0, "reset resistor bit");
    rd(8'hd7, 8'h00);
    rd(8'hb0, ram_img[0]);
    $display("test registers done");
    tick_en = 1'b1;
    for (int d = 0; d < 4; d++) scan(2'(d), 2'h3);
    for (int s = 0; s < 3; s++) scan(2'h3, 2'(s));
    report_and_stop();
  end
endmodule
